// ===== rtl/usync_pkg.sv
// Register map, field positions and encodings of the synchronous serial port.
// Function
// RULE1 - Either receive enable starts reception in synchronous mode.
// RULE2 - Receive data is sampled on the falling shift-clock edge.
// RULE3 - Single-receive enable alone receives exactly one word.
// RULE4 - Continuous-receive enable keeps receiving words until software clears it.
// RULE5 - With both enables set, continuous reception wins.
// RULE6 - Software programs divisor bytes and divisor width before master reception.
// RULE7 - Sync select, port enable and clock source together make master; device drives clock.
// RULE8 - Software keeps both receive enables clear until the last setup step.
// RULE9 - In nine-bit reception the ninth bit and errors show in receive status.
// RULE10 - Each received word sets the receive flag; request raised if enabled.
// RULE11 - Lower eight received bits are readable in the receive buffer.
// RULE12 - Clearing continuous-receive enable clears the receive error state.
// RULE13 - Clock source select clear means slave; clock taken from the pin.
// RULE14 - Slave mode keeps shifting on the external clock during low power.
// RULE15 - Slave mode matches master mode except for sleep behaviour.
// RULE16 - First of two written words moves to the shifter at once.
// RULE17 - Second word waits, flag clear, until the first has shifted out.
// RULE18 - Transmit flag with its enable set wakes the processor from sleep.
// RULE19 - Software sets up slave transmission with both receive enables clear.
// RULE20 - Software writes the transmit ninth bit before loading the buffer.
// RULE21 - Shifting starts only when transmit enable is set and data written.
// RULE22 - Master drives the shift clock; its idle level follows clock polarity.
// RULE23 - Transmit flag clears only when the transmit buffer is written.
// RULE24 - Read-only shifter-empty status is set whenever the shifter holds nothing.
// RULE25 - After a single-word reception the device clears single-receive enable.
package usync_pkg;

	// Register offsets (byte addresses on the bus)
	localparam int       OFS_W     = 5;
	localparam logic [4:0] OFS_RX_CTRL = 5'h00;
	localparam logic [4:0] OFS_RX_BUF  = 5'h04;
	localparam logic [4:0] OFS_TX_CTRL = 5'h08;
	localparam logic [4:0] OFS_BAUD    = 5'h0C;
	localparam logic [4:0] OFS_DIV_HI  = 5'h10;
	localparam logic [4:0] OFS_DIV_LO  = 5'h14;
	localparam logic [4:0] OFS_TX_BUF  = 5'h18;
	localparam logic [4:0] OFS_INT     = 5'h1C;

	// Receive status/control fields
	localparam int BIT_PORT_EN   = 7;
	localparam int BIT_NINE_RX   = 6;
	localparam int BIT_SINGLE_RX = 5;
	localparam int BIT_CONT_RX   = 4;
	localparam int BIT_FRAME_ERR = 2;
	localparam int BIT_OVERRUN   = 1;
	localparam int BIT_RX_NINTH  = 0;

	// Transmit status/control fields
	localparam int BIT_CLK_SRC   = 7;
	localparam int BIT_NINE_TX   = 6;
	localparam int BIT_TX_EN     = 5;
	localparam int BIT_SYNC_SEL  = 4;
	localparam int BIT_SR_EMPTY  = 1;
	localparam int BIT_TX_NINTH  = 0;

	// Baud control fields
	localparam int BIT_CLK_POL   = 4;
	localparam int BIT_WIDE_DIV  = 3;

	// Interrupt flag/enable register fields
	localparam int BIT_RX_FLAG   = 0;
	localparam int BIT_TX_FLAG   = 1;
	localparam int BIT_RX_IE     = 4;
	localparam int BIT_TX_IE     = 5;

	// Reset values and word lengths
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_HALF   = 16'h0000;
	localparam logic        RST_BIT    = 1'h0;
	localparam logic [3:0]  WORD_SHORT = 4'h8;
	localparam logic [3:0]  WORD_LONG  = 4'h9;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b01,
		RX_SHIFT = 2'b10
	} usync_rx_state_t;

endpackage

// ===== rtl/usync_top.sv
// Synchronous serial port: master reception and slave transmission behind APB.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
module usync_top import usync_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Processor state and requests
	input  wire logic              sleep_i,
	output logic                   irq_o,
	output logic                   wake_o,
	// Shift clock pin
	input  wire logic              shift_clock_pin_i,
	output logic                   shift_clock_pin_o,
	output logic                   shift_clock_pin_oe_o,
	// Shared data pin
	input  wire logic              shared_data_pin_i,
	output logic                   shared_data_pin_o,
	output logic                   shared_data_pin_oe_o
);

	if (ADDR_W < OFS_W) begin : g_bad_addr_w
		$error("ADDR_W too narrow for the register map");
	end

	// Control and status state
	logic            serial_port_enable, nine_bit_receive_select;
	logic            single_receive_enable, continuous_receive_enable;
	logic            overrun_error_flag, received_ninth_bit, receive_interrupt_flag;
	logic            clock_source_select, nine_bit_transmit_select, transmit_enable_bit;
	logic            sync_select, transmit_ninth_bit, clock_idle_polarity, wide_divisor_select;
	logic            receive_interrupt_enable, transmit_interrupt_enable;
	logic [7:0]      baud_divisor_high, baud_divisor_low, receive_buffer, transmit_buffer;
	logic            tbuf_full, tsr_full;
	logic [8:0]      transmit_shift_register, rsr;
	logic [3:0]      rx_cnt, tx_cnt;
	logic [15:0]     half_cnt;
	logic            phase;
	usync_rx_state_t rx_state;
	logic            ck_meta, ck_sync, ck_prev, dt_meta, dt_sync;

	// Bus decode
	logic       bus_acc, bus_wr, bus_rd, bus_first;
	logic [7:0] next_rdata;

	function automatic logic reg_sel(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
		reg_sel = ((a >> OFS_W) == '0) && (a[OFS_W-1:0] == ofs);
	endfunction

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		addr_ok = ((a >> OFS_W) == '0) && (a[1:0] == 2'h0);
	endfunction

	assign bus_first = psel_i & penable_i & ~pready_o;
	assign bus_acc   = psel_i & penable_i & pready_o;
	assign bus_wr    = bus_acc & pwrite_i & addr_ok(paddr_i);
	assign bus_rd    = bus_acc & ~pwrite_i & addr_ok(paddr_i);

	// Derived modes
	logic        master_en, slave_en, rx_go, tx_go, tx_move, transmit_interrupt_flag;
	logic        half_end, smp_take, rx_done, rx_accept, ck_rise, ck_fall;
	logic        wr_rx_ctrl, wr_tx_buf, rd_rx_buf;
	logic [3:0]  rx_words, tx_words, cnt_next;
	logic [15:0] divisor;
	logic [8:0]  next_rsr;

	assign master_en = serial_port_enable & sync_select & clock_source_select; // see RULE7
	assign slave_en  = serial_port_enable & sync_select & ~clock_source_select; // see RULE13
	// Continuous enable dominates through the rx_done checks that keep RX_SHIFT and keep single enable set
	assign rx_go     = master_en & (single_receive_enable | continuous_receive_enable)
		& ~overrun_error_flag & ~sleep_i; // see RULE1
	assign tx_go     = slave_en & transmit_enable_bit; // see RULE21
	assign divisor   = wide_divisor_select ? {baud_divisor_high, baud_divisor_low}
		: {RST_BYTE, baud_divisor_low};
	assign rx_words  = nine_bit_receive_select ? WORD_LONG : WORD_SHORT;
	assign tx_words  = nine_bit_transmit_select ? WORD_LONG : WORD_SHORT;
	assign half_end  = (half_cnt == RST_HALF);
	assign wr_rx_ctrl = bus_wr & reg_sel(paddr_i, OFS_RX_CTRL);
	assign wr_tx_buf  = bus_wr & reg_sel(paddr_i, OFS_TX_BUF);
	assign rd_rx_buf  = bus_rd & reg_sel(paddr_i, OFS_RX_BUF);

	// Falling clock edge: idle-low clock falls leaving the active half, idle-high entering it
	assign smp_take = (rx_state == RX_SHIFT) & rx_go & half_end
		& (phase ^ clock_idle_polarity); // see RULE2
	assign cnt_next = rx_cnt + {3'h0, smp_take};
	assign rx_done  = (rx_state == RX_SHIFT) & rx_go & half_end & phase & (cnt_next == rx_words);
	assign rx_accept = rx_done & (~receive_interrupt_flag | rd_rx_buf);

	always_comb begin
		next_rsr = rsr;
		if (smp_take && rx_cnt < WORD_LONG) begin
			next_rsr[rx_cnt] = dt_sync;
		end
	end

	// Pin synchronisers; the first stage is never looked at
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ck_meta <= RST_BIT;
			ck_sync <= RST_BIT;
			ck_prev <= RST_BIT;
			dt_meta <= RST_BIT;
			dt_sync <= RST_BIT;
		end else begin
			ck_meta <= shift_clock_pin_i;
			ck_sync <= ck_meta;
			ck_prev <= ck_sync;
			dt_meta <= shared_data_pin_i;
			dt_sync <= dt_meta;
		end
	end

	// Polarity applies to the external clock as well, as in master mode
	assign ck_rise = (ck_sync ^ clock_idle_polarity) & ~(ck_prev ^ clock_idle_polarity);
	assign ck_fall = ~(ck_sync ^ clock_idle_polarity) & (ck_prev ^ clock_idle_polarity);

	// Master receive sequencer and clock generator
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rx_state <= RX_IDLE;
			half_cnt <= RST_HALF;
			phase    <= RST_BIT;
			rx_cnt   <= 4'h0;
			rsr      <= 9'h000;
		end else begin
			unique case (rx_state)
				RX_IDLE: begin
					phase <= RST_BIT;
					if (rx_go) begin // see RULE1
						rx_state <= RX_SHIFT;
						half_cnt <= divisor;
						rx_cnt   <= 4'h0;
					end
				end
				RX_SHIFT: begin
					if (!rx_go) begin
						rx_state <= RX_IDLE;
						phase    <= RST_BIT;
					end else if (half_end) begin
						half_cnt <= divisor;
						phase    <= ~phase;
						rsr      <= next_rsr; // see RULE2
						rx_cnt   <= rx_done ? 4'h0 : cnt_next;
						// Single word ends here; continuous keeps shifting
						if (rx_done && !continuous_receive_enable) begin // see RULE4 RULE5
							rx_state <= RX_IDLE; // see RULE3
						end
					end else begin
						half_cnt <= half_cnt - 16'h0001;
					end
				end
			endcase
		end
	end

	// Receive status, data and single-enable auto clear
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			receive_buffer         <= RST_BYTE;
			received_ninth_bit     <= RST_BIT;
			receive_interrupt_flag <= RST_BIT;
			overrun_error_flag     <= RST_BIT;
			single_receive_enable  <= RST_BIT;
			continuous_receive_enable <= RST_BIT;
			serial_port_enable     <= RST_BIT;
			nine_bit_receive_select <= RST_BIT;
		end else begin
			if (wr_rx_ctrl) begin
				serial_port_enable        <= pwdata_i[BIT_PORT_EN];
				nine_bit_receive_select   <= pwdata_i[BIT_NINE_RX];
				continuous_receive_enable <= pwdata_i[BIT_CONT_RX];
				if (!pwdata_i[BIT_CONT_RX]) begin
					overrun_error_flag <= RST_BIT; // see RULE12
				end
			end
			if (wr_rx_ctrl) begin
				single_receive_enable <= pwdata_i[BIT_SINGLE_RX];
			end else if (rx_done && !continuous_receive_enable) begin
				single_receive_enable <= RST_BIT; // see RULE25
			end
			if (rd_rx_buf) begin
				receive_interrupt_flag <= RST_BIT;
			end
			// Set wins over a read in the same cycle
			if (rx_accept) begin
				receive_buffer         <= next_rsr[7:0]; // see RULE11
				received_ninth_bit     <= nine_bit_receive_select & next_rsr[8]; // see RULE9
				receive_interrupt_flag <= 1'h1; // see RULE10
			end else if (rx_done) begin
				overrun_error_flag     <= 1'h1; // see RULE9
			end
		end
	end

	// Transmit buffer and slave shifter; no sleep gating here on purpose
	assign tx_move = tx_go & tbuf_full & ~tsr_full; // see RULE16
	assign transmit_interrupt_flag = ~tbuf_full; // see RULE23

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			transmit_buffer <= RST_BYTE;
			tbuf_full       <= RST_BIT;
		end else begin
			if (tx_move) begin
				tbuf_full <= RST_BIT; // see RULE17
			end
			if (wr_tx_buf) begin
				transmit_buffer <= pwdata_i[7:0];
				tbuf_full       <= 1'h1; // see RULE23
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			transmit_shift_register <= 9'h000;
			tsr_full <= RST_BIT;
			tx_cnt   <= 4'h0;
		end else if (!tx_go) begin
			tsr_full <= RST_BIT;
			tx_cnt   <= 4'h0;
		end else if (tx_move) begin
			transmit_shift_register <= {nine_bit_transmit_select & transmit_ninth_bit,
				transmit_buffer}; // see RULE21
			tsr_full <= 1'h1;
			tx_cnt   <= 4'h0;
		end else if (tsr_full) begin
			// Bit 0 stands from load; later bits advance on each following rising edge
			if (ck_rise && tx_cnt != 4'h0) begin
				transmit_shift_register <= transmit_shift_register >> 1; // see RULE14
			end
			if (ck_fall) begin
				tx_cnt <= tx_cnt + 4'h1;
				if (tx_cnt + 4'h1 == tx_words) begin
					tsr_full <= RST_BIT; // see RULE17
				end
			end
		end
	end

	// Remaining configuration registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			clock_source_select <= RST_BIT;
			nine_bit_transmit_select <= RST_BIT;
			transmit_enable_bit <= RST_BIT;
			sync_select         <= RST_BIT;
			transmit_ninth_bit  <= RST_BIT;
			clock_idle_polarity <= RST_BIT;
			wide_divisor_select <= RST_BIT;
			baud_divisor_high   <= RST_BYTE;
			baud_divisor_low    <= RST_BYTE;
			receive_interrupt_enable  <= RST_BIT;
			transmit_interrupt_enable <= RST_BIT;
		end else if (bus_wr) begin
			if (reg_sel(paddr_i, OFS_TX_CTRL)) begin
				clock_source_select <= pwdata_i[BIT_CLK_SRC];
				nine_bit_transmit_select <= pwdata_i[BIT_NINE_TX];
				transmit_enable_bit <= pwdata_i[BIT_TX_EN];
				sync_select         <= pwdata_i[BIT_SYNC_SEL];
				transmit_ninth_bit  <= pwdata_i[BIT_TX_NINTH];
			end
			if (reg_sel(paddr_i, OFS_BAUD)) begin
				clock_idle_polarity <= pwdata_i[BIT_CLK_POL];
				wide_divisor_select <= pwdata_i[BIT_WIDE_DIV];
			end
			if (reg_sel(paddr_i, OFS_DIV_HI)) begin
				baud_divisor_high <= pwdata_i[7:0];
			end
			if (reg_sel(paddr_i, OFS_DIV_LO)) begin
				baud_divisor_low <= pwdata_i[7:0];
			end
			if (reg_sel(paddr_i, OFS_INT)) begin
				receive_interrupt_enable  <= pwdata_i[BIT_RX_IE];
				transmit_interrupt_enable <= pwdata_i[BIT_TX_IE];
			end
		end
	end

	// Read mux
	always_comb begin
		next_rdata = RST_BYTE;
		unique case (paddr_i[OFS_W-1:0])
			OFS_RX_CTRL: begin
				next_rdata[BIT_PORT_EN]   = serial_port_enable;
				next_rdata[BIT_NINE_RX]   = nine_bit_receive_select;
				next_rdata[BIT_SINGLE_RX] = single_receive_enable;
				next_rdata[BIT_CONT_RX]   = continuous_receive_enable;
				next_rdata[BIT_OVERRUN]   = overrun_error_flag;
				next_rdata[BIT_RX_NINTH]  = received_ninth_bit;
			end
			OFS_RX_BUF:  next_rdata = receive_buffer;
			OFS_TX_CTRL: begin
				next_rdata[BIT_CLK_SRC]  = clock_source_select;
				next_rdata[BIT_NINE_TX]  = nine_bit_transmit_select;
				next_rdata[BIT_TX_EN]    = transmit_enable_bit;
				next_rdata[BIT_SYNC_SEL] = sync_select;
				next_rdata[BIT_SR_EMPTY] = ~tsr_full; // see RULE24
				next_rdata[BIT_TX_NINTH] = transmit_ninth_bit;
			end
			OFS_BAUD: begin
				next_rdata[BIT_CLK_POL]  = clock_idle_polarity;
				next_rdata[BIT_WIDE_DIV] = wide_divisor_select;
			end
			OFS_DIV_HI:  next_rdata = baud_divisor_high;
			OFS_DIV_LO:  next_rdata = baud_divisor_low;
			OFS_TX_BUF:  next_rdata = transmit_buffer;
			OFS_INT: begin
				next_rdata[BIT_RX_FLAG] = receive_interrupt_flag;
				next_rdata[BIT_TX_FLAG] = transmit_interrupt_flag;
				next_rdata[BIT_RX_IE]   = receive_interrupt_enable;
				next_rdata[BIT_TX_IE]   = transmit_interrupt_enable;
			end
			default:     next_rdata = RST_BYTE;
		endcase
	end

	// APB answer: one wait state keeps every output registered
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pready_o  <= RST_BIT;
			pslverr_o <= RST_BIT;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= bus_first;
			pslverr_o <= bus_first & ~addr_ok(paddr_i);
			if (bus_first && !pwrite_i && addr_ok(paddr_i)) begin
				prdata_o <= {24'h000000, next_rdata};
			end
		end
	end

	// Pins and requests
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			shift_clock_pin_o    <= RST_BIT;
			shift_clock_pin_oe_o <= RST_BIT;
			shared_data_pin_o    <= RST_BIT;
			shared_data_pin_oe_o <= RST_BIT;
			irq_o  <= RST_BIT;
			wake_o <= RST_BIT;
		end else begin
			shift_clock_pin_o    <= clock_idle_polarity ^ phase; // see RULE22
			shift_clock_pin_oe_o <= master_en; // see RULE7
			shared_data_pin_o    <= transmit_shift_register[0];
			shared_data_pin_oe_o <= tx_go; // see RULE15
			irq_o  <= (receive_interrupt_flag & receive_interrupt_enable)
				| (transmit_interrupt_flag & transmit_interrupt_enable); // see RULE10
			wake_o <= sleep_i & transmit_interrupt_flag & transmit_interrupt_enable; // see RULE18
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_rx_start: assert property ((rx_state == RX_IDLE) && rx_go |=> rx_state == RX_SHIFT) // see RULE1
		else $error("reception did not start");
	chk_sample_fall: assert property (smp_take && $stable(clock_idle_polarity)
		|=> ##1 $fell(shift_clock_pin_o)) // see RULE2
		else $error("sample not at falling clock edge");
	chk_single_stop: assert property (rx_done && !continuous_receive_enable && !wr_rx_ctrl
		|=> rx_state == RX_IDLE && !single_receive_enable) // see RULE3
		else $error("single reception did not stop");
	chk_cont_run: assert property (rx_done && continuous_receive_enable && !wr_rx_ctrl
		&& !sleep_i |=> rx_state == RX_SHIFT) // see RULE4
		else $error("continuous reception stopped");
	chk_both_enables: assert property (rx_done && single_receive_enable
		&& continuous_receive_enable && !wr_rx_ctrl |=> single_receive_enable) // see RULE5
		else $error("single enable consumed under continuous reception");
	chk_ninth_bit: assert property (rx_accept && nine_bit_receive_select
		|=> received_ninth_bit == $past(next_rsr[8])) // see RULE9
		else $error("ninth bit not stored");
	chk_rx_flag: assert property (rx_accept |=> receive_interrupt_flag
		##1 (irq_o == receive_interrupt_enable || transmit_interrupt_enable)) // see RULE10
		else $error("receive flag or request missing");
	chk_rx_data: assert property (rx_accept |=> receive_buffer == $past(next_rsr[7:0])) // see RULE11
		else $error("received byte not stored");
	chk_err_clear: assert property (wr_rx_ctrl && !pwdata_i[BIT_CONT_RX] && !rx_done
		|=> !overrun_error_flag) // see RULE12
		else $error("error not cleared");
	chk_slave_clk: assert property (slave_en |=> !shift_clock_pin_oe_o) // see RULE13
		else $error("slave drives shift clock");
	chk_sleep_shift: assert property (tx_go && tsr_full && !tx_move && ck_fall && sleep_i
		|=> tx_cnt == $past(tx_cnt) + 4'h1 || !tsr_full) // see RULE14
		else $error("slave shifting stalled in sleep");
	chk_tx_move: assert property (tx_move && !wr_tx_buf |=> tsr_full && !tbuf_full) // see RULE16
		else $error("word not moved to shifter");
	chk_second_waits: assert property (tbuf_full && tsr_full && tx_go |=> tbuf_full) // see RULE17
		else $error("second word left buffer early");
	chk_wake: assert property (sleep_i && transmit_interrupt_flag
		&& transmit_interrupt_enable |=> wake_o) // see RULE18
		else $error("no wake on transmit flag");
	chk_tx_enable: assert property ($rose(tsr_full) |-> $past(transmit_enable_bit)) // see RULE21
		else $error("shifting without transmit enable");
	chk_clk_idle: assert property ((rx_state == RX_IDLE) [*2] && $stable(clock_idle_polarity)
		|=> shift_clock_pin_o == $past(clock_idle_polarity)) // see RULE22
		else $error("shift clock idle level wrong");
	chk_flag_clear: assert property ($rose(tbuf_full) |-> $past(wr_tx_buf)) // see RULE23
		else $error("transmit flag cleared without a write");
	chk_sr_empty: assert property ($fell(tsr_full) |-> $past(ck_fall) || $past(!tx_go)) // see RULE24
		else $error("shifter emptied before last bit");

	cov_single_word: cover property (rx_done && !continuous_receive_enable);
	cov_back_to_back: cover property (rx_done ##[1:1000] rx_done);
	cov_two_words: cover property (tx_move ##[1:1000] tx_move);
	cov_overrun: cover property ($rose(overrun_error_flag));

endmodule // usync_top

// ===== bench/usync_peer.sv
// Far-side serial device: feeds master receive bits, clocks slave words out.
`timescale 1ns/1ns
module usync_peer (
	// Wire levels
	input  wire logic sck_i,
	input  wire logic sd_i,
	// Driven by this device
	output logic      sck_o,
	output logic      sd_o
);
	logic q[$];
	initial begin
		sck_o = 1'b0;
		sd_o  = 1'b0;
	end
	// New bit after each rising edge; toggles when it has nothing to say
	always @(posedge sck_i) begin
		if (q.size() > 0)
			sd_o <= q.pop_front();
		else
			sd_o <= ~sd_o;
	end
	task automatic load(input logic [8:0] v, input int n);
		for (int i = 0; i < n; i++) q.push_back(v[i]);
	endtask
	// Clock only inside a frame; sampled late, the port resyncs our edges
	task automatic frame(output logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			sck_o = 1'b1;
			#80;
			sck_o = 1'b0;
			#79;
			d[i] = sd_i;
			#1;
		end
	endtask
endmodule // usync_peer

// ===== bench/testbench.sv
// Testbench: registers, master reception and slave transmission.
`timescale 1ns/1ns
module testbench;
	import usync_pkg::*;
	logic        clk_i, rst_n_i, psel, pen, pwr, sleep, prdy, perr, irq, wake, e;
	logic        sck_o, sck_oe, sd_o, sd_oe, p_sck, p_sd;
	logic [11:0] pa;
	logic [31:0] pwd, prd, r;
	logic [8:0]  v, w[$];
	logic [7:0]  g, ta, tb;
	int          n_fail, num_checks;
	wire         sck = sck_oe ? sck_o : p_sck;
	wire         sd  = sd_oe ? sd_o : p_sd;
	usync_top usync_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .sleep_i(sleep),
		.irq_o(irq), .wake_o(wake), .shift_clock_pin_i(sck),
		.shift_clock_pin_o(sck_o), .shift_clock_pin_oe_o(sck_oe),
		.shared_data_pin_i(sd), .shared_data_pin_o(sd_o),
		.shared_data_pin_oe_o(sd_oe));
	usync_peer usync_peer_i (.sck_i(sck), .sd_i(sd), .sck_o(p_sck), .sd_o(p_sd));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
		num_checks++;
		if (y !== x) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", s, x, y);
		end
	endtask
	// One transfer; pready, read data and error all taken at one rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		psel <= 1'b1;
		pwr <= wr;
		pa <= a;
		pwd <= {24'h0, d};
		@(posedge clk_i);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (prdy !== 1'b1 && k < 20);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (prdy !== 1'b1) begin
			n_fail++;
			complete_run();
		end
	endtask
	task automatic poll(input int b);
		int k;
		for (k = 0; k < 300; k++) begin
			apb(1'b0, OFS_INT, 8'h00);
			if (r[b] === 1'b1) break;
		end
		if (k == 300) begin
			n_fail++;
			complete_run();
		end
	endtask
	task automatic send(input int nb);
		v = 9'($urandom);
		if (nb == 8) v[8] = 1'b0;
		w.push_back(v);
		usync_peer_i.load(v, nb);
	endtask
	initial begin
		{rst_n_i, psel, pen, pwr, sleep, pa, pwd, n_fail, num_checks} = '0;
		void'($urandom(8814));
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		apb(1'b0, OFS_TX_CTRL, 8'h00);
		chk("tx_ctrl", 32'h02, r);
		apb(1'b0, 12'h020, 8'h00);
		chk("slverr", 1, e);
		$display("test reset done");
		apb(1'b1, OFS_DIV_LO, 8'h03);
		apb(1'b1, OFS_TX_CTRL, 8'h90);
		apb(1'b1, OFS_RX_CTRL, 8'h80);
		apb(1'b1, OFS_INT, 8'h10);
		send(9);
		apb(1'b1, OFS_RX_CTRL, 8'hE0);
		poll(BIT_RX_FLAG);
		@(negedge clk_i);
		chk("irq", 1, irq);
		v = w.pop_front();
		apb(1'b0, OFS_RX_CTRL, 8'h00);
		chk("rx_ctrl", 32'hC0 | v[8], r);
		apb(1'b0, OFS_RX_BUF, 8'h00);
		chk("rx_buf", v[7:0], r);
		repeat (100) @(posedge clk_i);
		apb(1'b0, OFS_INT, 8'h00);
		chk("rx_flag", 0, r[0]);
		$display("test single done");
		repeat (3) send(8);
		apb(1'b1, OFS_RX_CTRL, 8'hB0);
		poll(BIT_RX_FLAG);
		apb(1'b0, OFS_RX_BUF, 8'h00);
		chk("rx_buf", w.pop_front(), r);
		poll(BIT_RX_FLAG);
		repeat (120) @(posedge clk_i);
		apb(1'b0, OFS_RX_CTRL, 8'h00);
		chk("rx_ctrl", 32'hB2, r);
		apb(1'b1, OFS_RX_CTRL, 8'h80);
		apb(1'b0, OFS_RX_CTRL, 8'h00);
		chk("rx_ctrl", 32'h80, r);
		apb(1'b0, OFS_RX_BUF, 8'h00);
		chk("rx_buf", w.pop_front(), r);
		apb(1'b1, OFS_BAUD, 8'h10);
		@(posedge clk_i);
		@(negedge clk_i);
		chk("sck_idle", 1, sck_o);
		chk("sck_oe", 1, sck_oe);
		apb(1'b1, OFS_BAUD, 8'h00);
		$display("test continuous done");
		ta = 8'($urandom);
		tb = 8'($urandom);
		apb(1'b1, OFS_TX_CTRL, 8'h30);
		apb(1'b1, OFS_INT, 8'h20);
		@(posedge clk_i);
		sleep <= 1'b1;
		apb(1'b1, OFS_TX_BUF, ta);
		apb(1'b1, OFS_TX_BUF, tb);
		apb(1'b0, OFS_INT, 8'h00);
		chk("tx_flag", 0, r[1]);
		chk("wake", 0, wake);
		apb(1'b0, OFS_TX_CTRL, 8'h00);
		chk("tx_ctrl", 32'h30, r);
		usync_peer_i.frame(g);
		chk("tx_word0", ta, g);
		repeat (10) @(posedge clk_i);
		chk("wake", 1, wake);
		usync_peer_i.frame(g);
		chk("tx_word1", tb, g);
		repeat (10) @(posedge clk_i);
		apb(1'b0, OFS_TX_CTRL, 8'h00);
		chk("tx_ctrl", 32'h32, r);
		$display("test slave done");
		complete_run();
	end
endmodule // testbench
